// [rtl/jtsc_top.sv]
/*
  Scan data chains behind a four-bit instruction register: identification,
  bypass, boundary scan over the GPIO pads and reset pin, three debug chains.
  Assumes TCK, TMS, TDI and TRST_N come from an external tester; TCK is its own
  clock domain and the pad and core signals live on CLK_SYS.
*/
`timescale 1ns/1ps

module jtsc_chain
    import jtsc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    input  wire logic         capture,
    input  wire logic         shift,
    input  wire logic         update,
    input  wire logic         tdi,
    input  wire logic [W-1:0] cap_val,
    output logic      [W-1:0] sr_q,
    output logic      [W-1:0] upd_q
);
    // shift stage: capture, then move toward bit 0 which feeds TDO
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_q <= '0;
        end else if (en && capture) begin
            sr_q <= cap_val;
        end else if (en && shift) begin
            sr_q <= W'({tdi, sr_q} >> 1);
        end
    end

    // parallel hold stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            upd_q <= '0;
        end else if (en && update) begin
            upd_q <= sr_q;
        end
    end
endmodule // jtsc_chain

module jtsc_top
    import jtsc_pkg::*;
#(
    parameter logic [ID_LEN-1:0] ID_CODE = ID_CODE_DEF
) (
    // system clock, power-on reset, clock enable
    input  wire logic                CLK_SYS,
    input  wire logic                RESET_N,
    input  wire logic                CLK_EN,
    // test port
    input  wire logic                TCK,
    input  wire logic                TRST_N,
    input  wire logic                TMS,
    input  wire logic                TDI,
    output logic                     TDO_O,
    output logic                     TDO_OE_N,
    // pads
    input  wire logic [NUM_PADS-1:0] PAD_IN,
    output logic      [NUM_PADS-1:0] PAD_OUT,
    output logic      [NUM_PADS-1:0] PAD_OE_N,
    // core side of the pads
    input  wire logic [NUM_PADS-1:0] CORE_OUT,
    input  wire logic [NUM_PADS-1:0] CORE_OE,
    output logic      [NUM_PADS-1:0] CORE_IN,
    // external reset pin and core reset
    input  wire logic                RST_PIN_N,
    output logic                     CORE_RESET_N,
    // debug chains, TCK domain
    input  wire logic [DBG_LEN-1:0]  DBG_RESULT,
    output logic      [DBG_LEN-1:0]  DBG_DP_WORD,
    output logic      [DBG_LEN-1:0]  DBG_AP_WORD,
    output logic      [DBG_LEN-1:0]  DBG_CANCEL_WORD
);
    // TAP reset: power-on or test reset, never the external reset pin
    logic tap_rst_n;
    assign tap_rst_n = RESET_N & TRST_N;

    logic                en_s1_q, en_t_q;
    jtsc_pads_t          pads_s1_q, pads_t_q;
    logic                rstp_s1_q, rstp_t_q;
    jtsc_tap_t           st_q, st_d;
    logic [IR_LEN-1:0]   ir_sr_q, ir_q;
    jtsc_sel_t           sel;
    logic                cap_dr, sh_dr, up_dr;
    logic [BSR_LEN-1:0]  bsr_cap, bsr_sr, bsr_upd;
    logic [ID_LEN-1:0]   id_sr;
    logic                byp_sr;
    logic [DBG_LEN-1:0]  dp_sr, ap_sr, can_sr;
    logic                tdo_d, tdo_q, tdo_oe_n_q;
    logic                tgl_q, ext_t, int_t;

    // clock enable and pad values brought onto TCK
    always_ff @(posedge TCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            en_s1_q   <= 1'h0;
            en_t_q    <= 1'h0;
            pads_s1_q <= '0;
            pads_t_q  <= '0;
            rstp_s1_q <= 1'h0;
            rstp_t_q  <= 1'h0;
        end else begin
            en_s1_q   <= CLK_EN;
            en_t_q    <= en_s1_q;
            pads_s1_q <= '{pin: PAD_IN, out: CORE_OUT, oe: CORE_OE};
            pads_t_q  <= pads_s1_q;
            rstp_s1_q <= RST_PIN_N;
            rstp_t_q  <= rstp_s1_q;
        end
    end

    // TAP next state from TMS
    always_comb begin
        unique case (st_q)
            ST_RESET:    st_d = TMS ? ST_RESET    : ST_IDLE;
            ST_IDLE:     st_d = TMS ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   st_d = TMS ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   st_d = TMS ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: st_d = TMS ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: st_d = TMS ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: st_d = TMS ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: st_d = TMS ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   st_d = TMS ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   st_d = TMS ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   st_d = TMS ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: st_d = TMS ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: st_d = TMS ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: st_d = TMS ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: st_d = TMS ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   st_d = TMS ? ST_SEL_DR   : ST_IDLE;
        endcase
    end

    // TAP state register
    always_ff @(posedge TCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            st_q <= ST_RESET;
        end else if (en_t_q) begin
            st_q <= st_d;
        end
    end

    // instruction shift and current instruction
    always_ff @(posedge TCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sr_q <= IR_CAPTURE;
            ir_q    <= IR_IDCODE;
        end else if (en_t_q) begin
            if (st_q == ST_CAP_IR) begin
                ir_sr_q <= IR_CAPTURE;
            end else if (st_q == ST_SHIFT_IR) begin
                ir_sr_q <= {TDI, ir_sr_q[IR_LEN-1:1]};
            end
            if (st_q == ST_RESET) begin
                ir_q <= IR_IDCODE;
            end else if (st_q == ST_UPD_IR) begin
                ir_q <= ir_sr_q;
            end
        end
    end

    // instruction decode to the selected chain
    always_comb begin
        unique case (ir_q)
            IR_EXTEST, IR_INTEST, IR_SAMPLE: sel = SEL_BSR;
            IR_CANCEL: sel = SEL_CAN;
            IR_DP:     sel = SEL_DP;
            IR_AP:     sel = SEL_AP;
            IR_IDCODE: sel = SEL_ID;
            default:   sel = SEL_BYP;
        endcase
    end

    assign cap_dr = st_q == ST_CAP_DR;
    assign sh_dr  = st_q == ST_SHIFT_DR;
    assign up_dr  = st_q == ST_UPD_DR;
    assign ext_t  = ir_q == IR_EXTEST;
    assign int_t  = ir_q == IR_INTEST;

    // boundary capture: pad 0 nearest the test port, cells in, out, oe
    always_comb begin
        bsr_cap = '0;
        for (int i = 0; i < NUM_PADS; i++) begin
            bsr_cap[CELL_PER_PAD*i+CELL_IN]  = pads_t_q.pin[i];
            bsr_cap[CELL_PER_PAD*i+CELL_OUT] = pads_t_q.out[i];
            bsr_cap[CELL_PER_PAD*i+CELL_OE]  = pads_t_q.oe[i];
        end
        bsr_cap[CELL_RST] = rstp_t_q;
    end

    // the six data chains
    jtsc_chain #(.W(BSR_LEN)) u_bsr (
        .clk(TCK), .rst_n(tap_rst_n), .en(en_t_q), .tdi(TDI),
        .capture(cap_dr && sel == SEL_BSR), .shift(sh_dr && sel == SEL_BSR),
        .update(up_dr && sel == SEL_BSR), .cap_val(bsr_cap), .sr_q(bsr_sr), .upd_q(bsr_upd));
    jtsc_chain #(.W(ID_LEN)) u_id (
        .clk(TCK), .rst_n(tap_rst_n), .en(en_t_q), .tdi(TDI),
        .capture(cap_dr && sel == SEL_ID), .shift(sh_dr && sel == SEL_ID), .update(1'h0),
        .cap_val({ID_CODE[ID_LEN-1:1], ID_LSB}), .sr_q(id_sr), .upd_q());
    jtsc_chain #(.W(1)) u_byp (
        .clk(TCK), .rst_n(tap_rst_n), .en(en_t_q), .tdi(TDI),
        .capture(cap_dr && sel == SEL_BYP), .shift(sh_dr && sel == SEL_BYP), .update(1'h0),
        .cap_val(BYP_CAPTURE), .sr_q(byp_sr), .upd_q());
    jtsc_chain #(.W(DBG_LEN)) u_dp (
        .clk(TCK), .rst_n(tap_rst_n), .en(en_t_q), .tdi(TDI),
        .capture(cap_dr && sel == SEL_DP), .shift(sh_dr && sel == SEL_DP),
        .update(up_dr && sel == SEL_DP), .cap_val(DBG_RESULT), .sr_q(dp_sr), .upd_q(DBG_DP_WORD));
    jtsc_chain #(.W(DBG_LEN)) u_ap (
        .clk(TCK), .rst_n(tap_rst_n), .en(en_t_q), .tdi(TDI),
        .capture(cap_dr && sel == SEL_AP), .shift(sh_dr && sel == SEL_AP),
        .update(up_dr && sel == SEL_AP), .cap_val(DBG_RESULT), .sr_q(ap_sr), .upd_q(DBG_AP_WORD));
    jtsc_chain #(.W(DBG_LEN)) u_can (
        .clk(TCK), .rst_n(tap_rst_n), .en(en_t_q), .tdi(TDI),
        .capture(cap_dr && sel == SEL_CAN), .shift(sh_dr && sel == SEL_CAN),
        .update(up_dr && sel == SEL_CAN), .cap_val(DBG_RESULT), .sr_q(can_sr), .upd_q(DBG_CANCEL_WORD));

    // serial output mux
    always_comb begin
        tdo_d = byp_sr;
        if (st_q == ST_SHIFT_IR) begin
            tdo_d = ir_sr_q[0];
        end else begin
            unique case (sel)
                SEL_BSR: tdo_d = bsr_sr[0];
                SEL_ID:  tdo_d = id_sr[0];
                SEL_BYP: tdo_d = byp_sr;
                SEL_DP:  tdo_d = dp_sr[0];
                SEL_AP:  tdo_d = ap_sr[0];
                SEL_CAN: tdo_d = can_sr[0];
            endcase
        end
    end

    // TDO launched on the falling edge, driven only while shifting
    always_ff @(negedge TCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tdo_q      <= 1'h0;
            tdo_oe_n_q <= 1'h1;
        end else if (en_t_q) begin
            tdo_q      <= tdo_d;
            tdo_oe_n_q <= !(sh_dr || st_q == ST_SHIFT_IR);
        end
    end
    assign TDO_O    = tdo_q;
    assign TDO_OE_N = tdo_oe_n_q;

    // toggle announcing new hold values or a new instruction to CLK_SYS
    always_ff @(posedge TCK or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            tgl_q <= 1'h0;
        end else if (en_t_q && (st_q == ST_UPD_IR || (up_dr && sel == SEL_BSR)
                               || (st_q == ST_RESET && ir_q != IR_IDCODE))) begin
            tgl_q <= !tgl_q;
        end
    end

    // system side: synchronisers and the latched test mode
    logic               tg_s1_q, tg_s2_q, tg_s3_q;
    logic [NUM_PADS-1:0] pin_s1_q, pin_s2_q;
    logic               rp_s1_q, rp_s2_q;
    logic               ext_q, int_q;
    jtsc_pads_t         hold_q, hold_d;

    // hold values unpacked from the boundary hold stage
    always_comb begin
        hold_d = '0;
        for (int i = 0; i < NUM_PADS; i++) begin
            hold_d.pin[i] = bsr_upd[CELL_PER_PAD*i+CELL_IN];
            hold_d.out[i] = bsr_upd[CELL_PER_PAD*i+CELL_OUT];
            hold_d.oe[i]  = bsr_upd[CELL_PER_PAD*i+CELL_OE];
        end
    end

    // pin and toggle synchronisers
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            tg_s1_q  <= 1'h0;
            tg_s2_q  <= 1'h0;
            tg_s3_q  <= 1'h0;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            rp_s1_q  <= 1'h0;
            rp_s2_q  <= 1'h0;
        end else if (CLK_EN) begin
            tg_s1_q  <= tgl_q;
            tg_s2_q  <= tg_s1_q;
            tg_s3_q  <= tg_s2_q;
            pin_s1_q <= PAD_IN;
            pin_s2_q <= pin_s1_q;
            rp_s1_q  <= RST_PIN_N;
            rp_s2_q  <= rp_s1_q;
        end
    end

    // take over mode and hold values once the toggle has settled
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ext_q  <= 1'h0;
            int_q  <= 1'h0;
            hold_q <= '0;
        end else if (CLK_EN && (tg_s2_q != tg_s3_q)) begin
            ext_q  <= ext_t;
            int_q  <= int_t;
            hold_q <= hold_d;
        end
    end

    // pad and core multiplexers, core reset from the pin
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            PAD_OUT      <= '0;
            PAD_OE_N     <= '1;
            CORE_IN      <= '0;
            CORE_RESET_N <= 1'h0;
        end else if (CLK_EN) begin
            PAD_OUT      <= ext_q ? hold_q.out : CORE_OUT;
            PAD_OE_N     <= ~(ext_q ? hold_q.oe : CORE_OE);
            CORE_IN      <= int_q ? hold_q.pin : pin_s2_q;
            CORE_RESET_N <= rp_s2_q;
        end
    end

    // checks on the TCK side
    property p_id_lsb;
        @(posedge TCK) disable iff (!tap_rst_n) en_t_q && cap_dr && sel == SEL_ID |=> id_sr[0] == 1'b1;
    endproperty
    a_id_lsb: assert property (p_id_lsb) else $error("id chain lsb not one");
    property p_byp_zero;
        @(posedge TCK) disable iff (!tap_rst_n) en_t_q && cap_dr && sel == SEL_BYP |=> !byp_sr;
    endproperty
    a_byp_zero: assert property (p_byp_zero) else $error("bypass did not capture zero");
    property p_byp_shift;
        @(posedge TCK) disable iff (!tap_rst_n) en_t_q && sh_dr && sel == SEL_BYP |=> byp_sr == $past(TDI);
    endproperty
    a_byp_shift: assert property (p_byp_shift) else $error("bypass is not one stage");
    property p_ir_reset;
        @(posedge TCK) disable iff (!tap_rst_n) en_t_q && st_q == ST_RESET |=> ir_q == IR_IDCODE;
    endproperty
    a_ir_reset: assert property (p_ir_reset) else $error("id instruction not set in reset state");
    property p_ir_update;
        @(posedge TCK) disable iff (!tap_rst_n) en_t_q && st_q == ST_UPD_IR |=> ir_q == $past(ir_sr_q);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("instruction not updated");
    property p_bsr_update;
        @(posedge TCK) disable iff (!tap_rst_n)
            en_t_q && up_dr && sel == SEL_BSR |=> bsr_upd == $past(bsr_sr) ##1 $stable(bsr_upd) || up_dr;
    endproperty
    a_bsr_update: assert property (p_bsr_update) else $error("boundary hold not loaded");
    property p_dp_update;
        @(posedge TCK) disable iff (!tap_rst_n) en_t_q && up_dr && sel == SEL_DP |=> DBG_DP_WORD == $past(dp_sr);
    endproperty
    a_dp_update: assert property (p_dp_update) else $error("debug-port word not loaded");
    property p_tdo_drive;
        @(posedge TCK) disable iff (!tap_rst_n) en_t_q && $past(en_t_q) && sh_dr && $past(sh_dr) |-> !TDO_OE_N;
    endproperty
    a_tdo_drive: assert property (p_tdo_drive) else $error("TDO not driven while shifting");

    // checks on the system side
    property p_ext_pad;
        @(posedge CLK_SYS) disable iff (!RESET_N) CLK_EN && ext_q |=> PAD_OUT == $past(hold_q.out);
    endproperty
    a_ext_pad: assert property (p_ext_pad) else $error("pads not forced under external test");
    property p_core_rst;
        @(posedge CLK_SYS) disable iff (!RESET_N) CLK_EN && !rp_s2_q |=> !CORE_RESET_N;
    endproperty
    a_core_rst: assert property (p_core_rst) else $error("core not held in reset by pin");

    c_bsr_cap: cover property (@(posedge TCK) disable iff (!tap_rst_n) en_t_q && cap_dr && sel == SEL_BSR);
    c_ir_upd:  cover property (@(posedge TCK) disable iff (!tap_rst_n) en_t_q && st_q == ST_UPD_IR);
    c_dp_upd:  cover property (@(posedge TCK) disable iff (!tap_rst_n) en_t_q && up_dr && sel == SEL_DP);
    c_ext:     cover property (@(posedge CLK_SYS) disable iff (!RESET_N) ext_q);

endmodule // jtsc_top

// [pkg/jtsc_pkg.sv]
/*
  Shared constants and types for the scan-chain test port: instruction codes,
  chain lengths, boundary-cell positions, reset values, TAP states.
  Assumes a single set of GPIO pads plus one observe-only reset-pin cell.
*/
package jtsc_pkg;

    // chain and register lengths
    localparam int IR_LEN       = 4;
    localparam int ID_LEN       = 32;
    localparam int DBG_LEN      = 35;
    localparam int NUM_PADS     = 8;
    localparam int CELL_PER_PAD = 3;
    localparam int BSR_LEN      = CELL_PER_PAD * NUM_PADS + 1;

    // boundary cell positions inside one pad group, and the reset-pin cell
    localparam int CELL_IN      = 0;
    localparam int CELL_OUT     = 1;
    localparam int CELL_OE      = 2;
    localparam int CELL_RST     = CELL_PER_PAD * NUM_PADS;

    // instruction codes
    localparam logic [IR_LEN-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_LEN-1:0] IR_INTEST = 4'h1;
    localparam logic [IR_LEN-1:0] IR_SAMPLE = 4'h2;
    localparam logic [IR_LEN-1:0] IR_CANCEL = 4'h8;
    localparam logic [IR_LEN-1:0] IR_DP     = 4'ha;
    localparam logic [IR_LEN-1:0] IR_AP     = 4'hb;
    localparam logic [IR_LEN-1:0] IR_IDCODE = 4'he;
    localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hf;

    // values loaded at capture and after reset
    localparam logic [IR_LEN-1:0] IR_CAPTURE  = 4'h1;
    localparam logic              BYP_CAPTURE = 1'h0;
    localparam logic              ID_LSB      = 1'h1;
    localparam logic [ID_LEN-1:0] ID_CODE_DEF = 32'h0f0f_1001; // arbitrary value

    // TAP controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } jtsc_tap_t;

    // data chain placed between TDI and TDO
    typedef enum logic [2:0] {SEL_BSR, SEL_ID, SEL_BYP, SEL_DP, SEL_AP, SEL_CAN} jtsc_sel_t;

    // one value per pad for input, output and output enable
    typedef struct packed {
        logic [NUM_PADS-1:0] pin;
        logic [NUM_PADS-1:0] out;
        logic [NUM_PADS-1:0] oe;
    } jtsc_pads_t;

endpackage

// [test/jtsc_tester.sv]
/*
  tester model for the scan port: makes TCK, drives TMS and TDI, samples TDO.
  assumes the bench calls one task at a time; TCK stands still between calls.
*/
`timescale 1ns/1ps
module jtsc_tester (
    // test port toward the device
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    logic seen_q;

    // idle levels at time zero
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end

    // one TCK period; tdo is sampled just before the rising edge
    task automatic tick(input logic m, input logic d);
        #1 tms = m;
        tdi = d;
        #31 seen_q = tdo;
        tck = 1'h1;
        #32 tck = 1'h0;
    endtask

    // tdi is released outside shifts, so it toggles instead of holding
    task automatic idle(input logic m);
        tick(m, ~tdi);
    endtask

    // walk through Test-Logic-Reset, then to Idle
    task automatic tlr();
        repeat (5) idle(1'h1);
        idle(1'h0);
    endtask

    // instruction or data scan from Idle back to Idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        dout = '0;
        idle(1'h1);
        if (ir) idle(1'h1);
        idle(1'h0);
        idle(1'h0);
        for (int i = 0; i < n; i++) begin
            tick(logic'(i == n - 1), din[i]);
            dout[i] = seen_q;
        end
        idle(1'h1);
        idle(1'h0);
    endtask
endmodule // jtsc_tester

// [test/jtsc_top_test.sv]
/*
  self-checking bench for the scan chains: id, bypass, debug, boundary, resets.
  assumes a tester model drives the test port; TDO has a pull-up when released.
*/
`timescale 1ns/1ps
module jtsc_top_test;
    import jtsc_pkg::*;
    logic                clk, rst_n, trst_n, rst_pin_n, tck, tms, tdi, tdo, tdo_oe_n, core_rst_n, tdo_line;
    logic [NUM_PADS-1:0] pad_in, pad_out, pad_oe_n, core_out, core_oe, core_in;
    logic [DBG_LEN-1:0]  dbg_res, w_dp, w_ap, w_can, w;
    logic                clk_en;
    logic [63:0]         got;
    logic [63:0]         pre;
    logic [63:0]         e;
    int                  fail_count = 0;
    int                  n_checks   = 0;

    assign tdo_line = tdo_oe_n ? 1'h1 : tdo;

    // device and tester
    jtsc_top dut_u (.CLK_SYS(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .TCK(tck), .TRST_N(trst_n), .TMS(tms),
        .TDI(tdi), .TDO_O(tdo), .TDO_OE_N(tdo_oe_n), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE_N(pad_oe_n),
        .CORE_OUT(core_out), .CORE_OE(core_oe), .CORE_IN(core_in), .RST_PIN_N(rst_pin_n),
        .CORE_RESET_N(core_rst_n), .DBG_RESULT(dbg_res), .DBG_DP_WORD(w_dp), .DBG_AP_WORD(w_ap),
        .DBG_CANCEL_WORD(w_can));
    jtsc_tester tst_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

    // compare and count
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // instruction scan, checking the captured pattern
    task automatic ir(input logic [IR_LEN-1:0] c);
        tst_u.scan(1'h1, IR_LEN, {60'h0, c}, got);
        chk("ir capture", got[3:0], IR_CAPTURE);
    endtask

    // power-on reset with TCK edges inside it, then the enable start-up
    task automatic por();
        @(posedge clk) rst_n <= 1'h0;
        repeat (2) tst_u.idle(1'h1);
        @(posedge clk) rst_n <= 1'h1;
        repeat (2) tst_u.idle(1'h1);
        tst_u.idle(1'h0);
    endtask

    task automatic t_id();
        tst_u.scan(1'h0, ID_LEN, 64'h0, got);
        chk("idcode", got[31:0], {ID_CODE_DEF[31:1], ID_LSB});
    endtask

    // bypass and every unused code give a one-bit path that captures zero
    task automatic t_bypass();
        logic [3:0] codes [9] = '{4'hf, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd};
        foreach (codes[k]) begin
            ir(codes[k]);
            tst_u.scan(1'h0, 2, 64'h1, got);
            chk("bypass", got[1:0], {1'h1, BYP_CAPTURE});
        end
    endtask

    // each debug chain is 35 bits: the 36th bit out is the first bit in
    task automatic t_dbg();
        logic [3:0] codes [3] = '{IR_DP, IR_AP, IR_CANCEL};
        foreach (codes[k]) begin
            pre = 64'h9_3c3c_1235 ^ 64'(k * 6);
            ir(codes[k]);
            tst_u.scan(1'h0, 36, pre, got);
            chk("dbg capture", got[35:0], {pre[0], dbg_res});
            w = (k == 0) ? w_dp : (k == 1) ? w_ap : w_can;
            chk("dbg word", w, pre[35:1]);
        end
    endtask

    // sample pads, preload, then force them out and in
    task automatic t_bound();
        pre = 64'h0_01a5_c36e;
        e = '0;
        for (int i = 0; i < NUM_PADS; i++) begin
            e[3*i+CELL_IN] = pad_in[i];
            e[3*i+CELL_OUT] = core_out[i];
            e[3*i+CELL_OE] = core_oe[i];
        end
        e[CELL_RST] = rst_pin_n;
        ir(IR_SAMPLE);
        tst_u.scan(1'h0, BSR_LEN, pre, got);
        chk("boundary", got, e);
        ir(IR_EXTEST);
        repeat (8) @(posedge clk);
        for (int i = 0; i < NUM_PADS; i++) begin
            chk("pad out", pad_out[i], pre[3*i+CELL_OUT]);
            chk("pad oe", pad_oe_n[i], !pre[3*i+CELL_OE]);
        end
        ir(IR_INTEST);
        repeat (8) @(posedge clk);
        for (int i = 0; i < NUM_PADS; i++) chk("core in", core_in[i], pre[3*i+CELL_IN]);
        ir(IR_BYPASS);
        repeat (8) @(posedge clk);
        chk("pass out", {pad_out, pad_oe_n, core_in}, {core_out, ~core_oe, pad_in});
    endtask

    // pin reset keeps the instruction; the three TAP resets restore the id chain
    task automatic t_resets();
        for (int k = 0; k < 3; k++) begin
            ir(IR_BYPASS);
            // with the enable low the system side must not follow the pin
            @(posedge clk) clk_en <= 1'h0;
            rst_pin_n <= 1'h0;
            repeat (5) @(posedge clk);
            chk("frozen reset", core_rst_n, 1'h1);
            clk_en <= 1'h1;
            repeat (5) @(posedge clk);
            chk("core reset", core_rst_n, 1'h0);
            rst_pin_n <= 1'h1;
            repeat (5) @(posedge clk);
            chk("core reset", core_rst_n, 1'h1);
            tst_u.scan(1'h0, 2, 64'h1, got);
            chk("kept bypass", got[1:0], 2'h2);
            if (k == 0) tst_u.tlr();
            if (k == 1) begin
                @(posedge clk) trst_n <= 1'h0;
                @(posedge clk) trst_n <= 1'h1;
                // the synced enable restarts at zero: two TCK edges before TMS counts
                repeat (2) tst_u.idle(1'h1);
                tst_u.idle(1'h0);
            end
            if (k == 2) por();
            t_id();
        end
    endtask

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // watchdog, well beyond the expected run of about 40 us
    initial begin
        #300000;
        fail_count++;
        give_verdict();
    end

    initial begin
        rst_n = 1'h0;
        clk_en = 1'h1;
        trst_n = 1'h1;
        rst_pin_n = 1'h1;
        pad_in = 8'h5a;
        core_out = 8'h33;
        core_oe = 8'h0f;
        dbg_res = 35'h5_1234_abcd;
        por();
        t_id();
        t_bypass();
        t_dbg();
        t_bound();
        t_resets();
        give_verdict();
    end
endmodule // jtsc_top_test
